/* File: rtl/host_decode_and_strap_capture.sv */
/*
 * host decode and strap capture: decodes the host address into the
 * index/data registers, moves bytes on the 8-bit host data bus, skips
 * decode for dma, and captures straps during reset.
 * assumes host pins and straps are asynchronous to clk; the avalon
 * master runs on clk.
 */
`timescale 1ns/1ps
module host_decode_and_strap_capture
    import host_port_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic [ADDR_W-1:0]    host_address,
    input  wire logic                 address_qualifier,
    input  wire logic                 host_rd_n,
    input  wire logic                 host_wr_n,
    input  wire logic                 dma_ack_n,
    input  wire logic [DATA_W-1:0]    host_data_bus_in,
    output logic      [DATA_W-1:0]    host_data_bus_out,
    output logic                      host_data_bus_oe_n,
    input  wire logic [1:0]           base_select_straps,
    input  wire logic [4:0]           default_config_straps,
    input  wire logic                 clock_option_strap,
    output logic      [4:0]           config_select,
    input  wire logic [AV_ADDR_W-1:0] avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest
);

    // two-flop synchronisers for all pin inputs
    localparam int SYNC_W = ADDR_W + 4 + DATA_W + 8;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    always_ff @(posedge clk) begin
        sync1_reg <= {host_address, address_qualifier, host_rd_n, host_wr_n, dma_ack_n,
                      host_data_bus_in, base_select_straps, default_config_straps,
                      clock_option_strap};
        sync2_reg <= sync1_reg;
    end

    host_req_t          req;
    logic [DATA_W-1:0]  din;
    straps_t            straps;
    assign req    = '{rd: ~sync2_reg[SYNC_W-ADDR_W-2], wr: ~sync2_reg[SYNC_W-ADDR_W-3],
                      dack: ~sync2_reg[SYNC_W-ADDR_W-4], qual: sync2_reg[SYNC_W-ADDR_W-1],
                      addr: sync2_reg[SYNC_W-1 -: ADDR_W]};
    assign din    = sync2_reg[15:8];
    assign straps = sync2_reg[7:0];

    // register state
    logic              ctrl_en_reg,  ctrl_en_next;
    straps_t           strap_reg,    strap_next;
    logic [DATA_W-1:0] index_reg,    index_next;
    logic [DATA_W-1:0] data_reg,     data_next;
    logic [DATA_W-1:0] dout_reg,     dout_next;
    logic              oe_n_reg,     oe_n_next;
    logic              wr_d_reg,     wr_d_next;
    logic [31:0]       rdata_reg,    rdata_next;
    logic              wait_reg,     wait_next;
    sel_t              last_sel_reg, last_sel_next;

    logic [ADDR_W-1:0] base_addr;
    sel_t              sel;

    // base address from straps
    always_comb begin
        case (strap_reg.base)
            2'b00:   base_addr = BASE_ADDR_0;
            2'b01:   base_addr = BASE_ADDR_1;
            2'b10:   base_addr = BASE_ADDR_2;
            default: base_addr = BASE_ADDR_3;
        endcase
    end

    // access decode
    always_comb begin
        sel = SEL_NONE;
        if (req.dack) begin
            sel = SEL_DMA;
        end else if (!req.qual) begin
            if (req.addr == base_addr) begin
                sel = SEL_INDEX;
            end else if (req.addr == base_addr + DATA_OFFSET) begin
                sel = SEL_DATA;
            end
        end
    end

    always_comb begin
        ctrl_en_next  = ctrl_en_reg;
        strap_next    = strap_reg;
        index_next    = index_reg;
        data_next     = data_reg;
        dout_next     = dout_reg;
        oe_n_next     = 1'b1;
        wr_d_next     = req.wr;
        last_sel_next = last_sel_reg;
        rdata_next    = rdata_reg;
        wait_next     = 1'b1;
        if (srst) begin
            strap_next = straps;
        end
        // host side
        if (ctrl_en_reg && req.rd && sel != SEL_NONE) begin
            oe_n_next = 1'b0;
            dout_next = (sel == SEL_INDEX) ? index_reg : data_reg;
        end
        if (ctrl_en_reg && req.wr && !wr_d_reg && sel != SEL_NONE) begin
            last_sel_next = sel;
            if (sel == SEL_INDEX) begin
                index_next = din;
            end else begin
                data_next = din;
            end
        end
        // avalon slave: one wait cycle then answer
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next  = 1'b0;
            rdata_next = UNMAPPED_DATA;
            case (avs_address)
                OFF_CTRL:   rdata_next[CTRL_EN_BIT] = ctrl_en_reg;
                OFF_STRAP: begin
                    rdata_next[STRAP_BASE_LSB +: 2] = strap_reg.base;
                    rdata_next[STRAP_CFG_LSB +: 5]  = strap_reg.cfg;
                end
                OFF_SETUP:  rdata_next[SETUP_CLK_BIT] = strap_reg.clk_opt;
                OFF_ACCESS: rdata_next = {14'h0, last_sel_reg, index_reg, data_reg};
                default:    rdata_next = UNMAPPED_DATA;
            endcase
        end
        // a write lands at the edge that sees waitrequest low
        if (avs_write && !wait_reg && avs_byteenable[0] && avs_address == OFF_CTRL) begin
            ctrl_en_next = avs_writedata[CTRL_EN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_en_reg  <= CTRL_RESET;
            index_reg    <= '0;
            data_reg     <= '0;
            dout_reg     <= '0;
            oe_n_reg     <= 1'b1;
            wr_d_reg     <= 1'b0;
            rdata_reg    <= '0;
            wait_reg     <= 1'b1;
            last_sel_reg <= SEL_NONE;
        end else begin
            ctrl_en_reg  <= ctrl_en_next;
            index_reg    <= index_next;
            data_reg     <= data_next;
            dout_reg     <= dout_next;
            oe_n_reg     <= oe_n_next;
            wr_d_reg     <= wr_d_next;
            rdata_reg    <= rdata_next;
            wait_reg     <= wait_next;
            last_sel_reg <= last_sel_next;
        end
        strap_reg <= strap_next;
    end

    always_ff @(posedge clk) begin
        config_select <= strap_reg.cfg;
    end

    assign host_data_bus_out  = dout_reg;
    assign host_data_bus_oe_n = oe_n_reg;
    assign avs_readdata       = rdata_reg;
    assign avs_waitrequest    = wait_reg;

    qual_blocks_sel_a: assert property (@(posedge clk) disable iff (srst)
        (req.qual && !req.dack) |-> sel == SEL_NONE)
        else $error("address selected while qualifier high");
    dma_ignores_qual_a: assert property (@(posedge clk) disable iff (srst)
        req.dack |-> sel == SEL_DMA)
        else $error("dma access not selected");
    drive_only_read_a: assert property (@(posedge clk) disable iff (srst)
        !oe_n_reg |-> $past(req.rd) && $past(sel) != SEL_NONE)
        else $error("bus driven outside selected read");
    strap_latch_a: assert property (@(posedge clk)
        ($past(srst) && $past(srst, 3)) |-> strap_reg.clk_opt == $past(straps.clk_opt))
        else $error("clock option not latched in reset");
    base_decode_a: assert property (@(posedge clk) disable iff (srst)
        (!req.dack && !req.qual && req.addr == base_addr) |-> sel == SEL_INDEX)
        else $error("index not decoded at base");
    index_write_a: assert property (@(posedge clk) disable iff (srst)
        (ctrl_en_reg && req.wr && !wr_d_reg && sel == SEL_INDEX) |=> index_reg == $past(din))
        else $error("index write lost");
    cfg_follow_a: assert property (@(posedge clk) disable iff (srst)
        ##1 config_select == $past(strap_reg.cfg))
        else $error("config select mismatch");
    avs_answer_a: assert property (@(posedge clk) disable iff (srst)
        (avs_read && wait_reg) |=> !wait_reg)
        else $error("avalon answer late");
    dma_write_a: assert property (@(posedge clk) disable iff (srst)
        (ctrl_en_reg && req.wr && !wr_d_reg && req.dack) |=> data_reg == $past(din))
        else $error("dma write lost");
    qual_write_a: assert property (@(posedge clk) disable iff (srst)
        (req.qual && !req.dack && req.wr) |=> $stable(index_reg) && $stable(data_reg))
        else $error("write landed while qualifier high");
    cfg_latch_a: assert property (@(posedge clk)
        ($past(srst) && $past(srst, 3)) |-> strap_reg.cfg == $past(straps.cfg))
        else $error("config straps not latched in reset");
    ctrl_write_a: assert property (@(posedge clk) disable iff (srst)
        (avs_write && !wait_reg && avs_byteenable[0] && avs_address == OFF_CTRL)
        |=> ctrl_en_reg == $past(avs_writedata[CTRL_EN_BIT]))
        else $error("ctrl write lost");

endmodule

/* File: rtl/host_port_pkg.sv */
/*
 * package for the host decode and strap capture block: bus offsets,
 * host address map, strap layouts and carrier structs.
 * assumes a single 25 MHz clock domain.
 */
package host_port_pkg;

    localparam int ADDR_W      = 11;
    localparam int DATA_W      = 8;
    localparam int AV_ADDR_W   = 4;

    // avalon word byte addresses of the control registers
    localparam logic [AV_ADDR_W-1:0] OFF_CTRL    = 4'h0;
    localparam logic [AV_ADDR_W-1:0] OFF_STRAP   = 4'h4;
    localparam logic [AV_ADDR_W-1:0] OFF_SETUP   = 4'h8;
    localparam logic [AV_ADDR_W-1:0] OFF_ACCESS  = 4'hC;

    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // ctrl register: bit 0 enables the host port
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_RESET = 1'b1;

    // strap layout in the strap status and setup registers
    localparam int STRAP_BASE_LSB = 0;
    localparam int STRAP_CFG_LSB  = 2;
    localparam int SETUP_CLK_BIT  = 0;

    // the four index/data base addresses chosen by the base straps
    localparam logic [ADDR_W-1:0] BASE_ADDR_0 = 11'h398;
    localparam logic [ADDR_W-1:0] BASE_ADDR_1 = 11'h26E;
    localparam logic [ADDR_W-1:0] BASE_ADDR_2 = 11'h15C;
    localparam logic [ADDR_W-1:0] BASE_ADDR_3 = 11'h2E;
    localparam logic [ADDR_W-1:0] DATA_OFFSET = 11'h001;

    typedef enum logic [1:0] {
        SEL_NONE  = 2'b00,
        SEL_INDEX = 2'b01,
        SEL_DATA  = 2'b10,
        SEL_DMA   = 2'b11
    } sel_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic              dack;
        logic              qual;
        logic [ADDR_W-1:0] addr;
    } host_req_t;

    typedef struct packed {
        logic [1:0] base;
        logic [4:0] cfg;
        logic       clk_opt;
    } straps_t;

endpackage

/* File: testbench/host_cpu_model.sv */
/* host processor model: strobes, address, qualifier, dma ack, data bus.
   assumes registered device outputs and the one device clock. */
`timescale 1ns/1ps
module host_cpu_model
    import host_port_pkg::*;
(
    input  wire logic              clk,
    output logic      [ADDR_W-1:0] host_address,
    output logic                   address_qualifier,
    output logic                   host_rd_n,
    output logic                   host_wr_n,
    output logic                   dma_ack_n,
    output logic      [DATA_W-1:0] host_data_bus_in,
    input  wire logic [DATA_W-1:0] host_data_bus_out,
    input  wire logic              host_data_bus_oe_n
);
    logic              drv;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] last;
    // resolved bus; undriven bus shows inverted last value
    assign host_data_bus_in = !host_data_bus_oe_n ? host_data_bus_out : drv ? wd : ~last;
    always_ff @(posedge clk) last <= host_data_bus_in;
    initial begin
        {host_address, address_qualifier, drv, wd} = '0;
        {host_rd_n, host_wr_n, dma_ack_n} = 3'b111;
    end
    // one strobe held 5 edges, then 4 idle edges for release
    task automatic cycle(input logic rd, dma, qual, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                         output logic on);
        @(posedge clk);
        host_address <= a;
        address_qualifier <= qual;
        dma_ack_n <= !dma;
        wd <= d;
        drv <= !rd;
        host_rd_n <= !rd;
        host_wr_n <= rd;
        repeat (4) @(posedge clk);
        @(negedge clk);
        q = host_data_bus_in;
        on = !host_data_bus_oe_n;
        @(posedge clk);
        {host_rd_n, host_wr_n, dma_ack_n, drv} <= 4'b1110;
        repeat (4) @(posedge clk);
    endtask
endmodule

/* File: testbench/tb_host_decode_and_strap_capture.sv */
/* bench for host decode and strap capture: avalon and host bus tasks.
   assumes the host_cpu_model partner and a 25 MHz clock. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_host_decode_and_strap_capture
    import host_port_pkg::*;
;
    localparam logic [ADDR_W-1:0] BASES [4] = '{BASE_ADDR_0, BASE_ADDR_1, BASE_ADDR_2, BASE_ADDR_3};
    logic clk, srst, address_qualifier, host_rd_n, host_wr_n, dma_ack_n, host_data_bus_oe_n;
    logic [ADDR_W-1:0]    host_address;
    logic [DATA_W-1:0]    host_data_bus_in, host_data_bus_out, q8, ix, dv;
    logic [1:0]           base_select_straps;
    logic [4:0]           default_config_straps, config_select, c;
    logic                 clock_option_strap, avs_read, avs_write, avs_waitrequest, on;
    logic [AV_ADDR_W-1:0] avs_address;
    logic [31:0]          avs_writedata, avs_readdata, q;
    logic [3:0]           avs_byteenable;
    int                   errors, num_checks;
    host_decode_and_strap_capture uut (.clk(clk), .srst(srst), .host_address(host_address),
        .address_qualifier(address_qualifier), .host_rd_n(host_rd_n),
        .host_wr_n(host_wr_n), .dma_ack_n(dma_ack_n), .host_data_bus_in(host_data_bus_in),
        .host_data_bus_out(host_data_bus_out), .host_data_bus_oe_n(host_data_bus_oe_n),
        .base_select_straps(base_select_straps),
        .default_config_straps(default_config_straps),
        .clock_option_strap(clock_option_strap), .config_select(config_select),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    host_cpu_model cpu (.clk(clk), .host_address(host_address),
        .address_qualifier(address_qualifier), .host_rd_n(host_rd_n),
        .host_wr_n(host_wr_n), .dma_ack_n(dma_ack_n), .host_data_bus_in(host_data_bus_in),
        .host_data_bus_out(host_data_bus_out), .host_data_bus_oe_n(host_data_bus_oe_n));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic wrap_up();
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic av(input logic wr, input logic [AV_ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            errors++;
            wrap_up();
        end
    endtask
    initial begin
        srst = 1'b1;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        {base_select_straps, default_config_straps, clock_option_strap} = '0;
        for (int b = 0; b < 4; b++) begin
            c = 5'(b * 9 + 5);
            ix = 8'hC0 + 8'(b);
            dv = 8'h0F + 8'(b);
            @(posedge clk);
            base_select_straps <= 2'(b);
            default_config_straps <= c;
            clock_option_strap <= b[0];
            srst <= 1'b1;
            repeat (5) @(posedge clk);
            srst <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK("config_select", c, config_select)
            av(0, OFF_SETUP, 0); `CHK("setup bit", b[0], q[SETUP_CLK_BIT])
            av(0, OFF_STRAP, 0); `CHK("base strap", 2'(b), q[STRAP_BASE_LSB +: 2])
            `CHK("cfg strap", c, q[STRAP_CFG_LSB +: 5])
            av(0, OFF_CTRL, 0); `CHK("ctrl reset", CTRL_RESET, q[CTRL_EN_BIT])
            cpu.cycle(0, 0, 0, BASES[b], ix, q8, on);
            cpu.cycle(0, 0, 0, BASES[b] + DATA_OFFSET, dv, q8, on);
            cpu.cycle(1, 0, 0, BASES[b], 0, q8, on); `CHK("index rd", ix, q8)
            `CHK("rd drive", 1'b1, on)
            cpu.cycle(1, 0, 0, BASES[b] + DATA_OFFSET, 0, q8, on); `CHK("data rd", dv, q8)
            av(0, OFF_ACCESS, 0); `CHK("access", {ix, dv}, q[15:0])
            `CHK("last sel", SEL_DATA, q[17:16])
            cpu.cycle(1, 0, 1, BASES[b], 0, q8, on); `CHK("qual rd", 1'b0, on)
            cpu.cycle(0, 0, 1, BASES[b] + DATA_OFFSET, 8'h33, q8, on);
            av(0, OFF_ACCESS, 0); `CHK("qual wr", {ix, dv}, q[15:0])
            cpu.cycle(1, 0, 0, BASES[b] + 11'h002, 0, q8, on); `CHK("miss rd", 1'b0, on)
            cpu.cycle(0, 1, 1, ~BASES[b], 8'hE7 - 8'(b), q8, on);
            cpu.cycle(1, 1, 1, 11'h7FF, 0, q8, on); `CHK("dma rd", 8'hE7 - 8'(b), q8)
            `CHK("dma drive", 1'b1, on)
        end
        av(0, 4'h1, 0); `CHK("unmapped", UNMAPPED_DATA, q)
        av(1, OFF_CTRL, 0);
        cpu.cycle(1, 0, 0, BASES[3], 0, q8, on); `CHK("disabled rd", 1'b0, on)
        av(1, OFF_CTRL, 1);
        av(0, OFF_CTRL, 0); `CHK("ctrl wr", 1'b1, q[CTRL_EN_BIT])
        wrap_up();
    end
endmodule
